// >>> hw/uef_top.sv
// Purpose: USB error detection flags with an AXI4-Lite register slave
// Assumes: Link events arrive as single-cycle pulses synchronous to aclk
// Notes:   Flags set one edge after their event; irq follows one edge later
`timescale 1ns/1ns
`default_nettype none
`include "uef_defs.svh"

// Behaviour
// - A received packet with a bit stuffing violation is rejected and sets flag bit 7.
// - An invalid descriptor table base or buffer address sets flag bit 6.
// - A memory bus grant that comes too late, overflowing or underflowing, sets bit 5.
// - A received data packet truncated for lack of buffer room also sets bit 5.
// - More than sixteen idle bit times after an end of packet with no response set bit 4.
// - A data field that is not a whole number of bytes sets bit 3; whole bytes leave it.
// - A data packet failing its 16-bit CRC is rejected and sets bit 2; passing ones with no bit stuffing violation are accepted.
// - In host mode bit 1 reports traffic still in progress as the frame countdown hits zero.
// - Each flag holds until software writes a one to it; a zero write leaves it unchanged.
// - Hardware sets flags independently of software writes, and all are clear after reset.
// - Bits 31 to 8 of the flag register always read as zero.
module uef_top (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [`UEF_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [`UEF_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic      [1:0]             s_axi_bresp,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [`UEF_ADDR_W-1:0] s_axi_araddr,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic      [`UEF_DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]             s_axi_rresp,
   input  wire logic                   rx_pkt_end,
   input  wire logic                   rx_data_pkt,
   input  wire logic                   rx_stuff_err,
   input  wire logic                   rx_crc16_ok,
   input  wire logic [2:0]             rx_partial_bits,
   input  wire logic                   rx_truncated,
   input  wire logic                   bdt_addr_err,
   input  wire logic                   buf_addr_err,
   input  wire logic                   mem_grant_late,
   input  wire logic                   eop_seen,
   input  wire logic                   resp_start,
   input  wire logic                   bit_tick,
   input  wire logic                   sof_count_zero,
   input  wire logic                   link_busy,
   input  wire logic                   token_end,
   input  wire logic                   token_crc5_ok,
   input  wire logic                   pid_check,
   input  wire logic                   pid_ok,
   output logic      [`UEF_FLAG_W-1:0] usb_error_flags,
   output logic                        rx_pkt_accept,
   output logic                        rx_pkt_reject,
   output logic                        irq
);
   import uef_pkg::*;

   logic [`UEF_ADDR_W-1:0] awaddr_ff;
   logic                   aw_held_ff;
   logic [`UEF_DATA_W-1:0] wdata_ff;
   logic [3:0]             wstrb_ff;
   logic                   w_held_ff;
   logic                   awready_ff;
   logic                   wready_ff;
   logic                   bvalid_ff;
   logic [1:0]             bresp_ff;
   logic                   arready_ff;
   logic                   rvalid_ff;
   logic [`UEF_DATA_W-1:0] rdata_ff;
   logic [1:0]             rresp_ff;
   logic                   nxt_aw_held;
   logic                   nxt_w_held;
   logic                   nxt_bvalid;
   logic                   nxt_rvalid;
   logic                   wr_commit;
   uef_reg_type            wr_sel;
   logic [`UEF_FLAG_W-1:0] enable_ff;
   logic                   host_mode_ff;
   logic [`UEF_FLAG_W-1:0] set_vec;
   logic [`UEF_FLAG_W-1:0] clr_vec;
   logic [`UEF_FLAG_W-1:0] flags;
   logic                   turn_timeout;
   logic                   bad_pkt;
   logic                   accept_ff;
   logic                   reject_ff;
   logic                   irq_ff;

   function automatic uef_reg_type uef_decode(input logic [`UEF_ADDR_W-1:0] addr);
      case (addr)
         `UEF_OFS_FLAGS:  uef_decode = UEF_REG_FLAGS;
         `UEF_OFS_CLEAR:  uef_decode = UEF_REG_CLEAR;
         `UEF_OFS_ENABLE: uef_decode = UEF_REG_ENABLE;
         `UEF_OFS_CTRL:   uef_decode = UEF_REG_CTRL;
         default:         uef_decode = UEF_REG_NONE;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   assign wr_commit = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_sel    = uef_decode(awaddr_ff);

   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held  = w_held_ff;
      nxt_bvalid  = bvalid_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
      end
      if (wr_commit) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
      end else if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
         bresp_ff   <= `UEF_RESP_OKAY;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         bvalid_ff  <= nxt_bvalid;
         awready_ff <= !nxt_aw_held && !nxt_bvalid && !(w_held_ff && aw_held_ff);
         wready_ff  <= !nxt_w_held && !nxt_bvalid && !(w_held_ff && aw_held_ff);
         if (s_axi_awvalid && awready_ff) begin
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_ff) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_commit) begin
            bresp_ff <= (wr_sel == UEF_REG_NONE) ? `UEF_RESP_SLVERR : `UEF_RESP_OKAY;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_ff    <= `UEF_ENABLE_RST;
         host_mode_ff <= 1'b0;
      end else if (wr_commit && wstrb_ff[0]) begin
         if (wr_sel == UEF_REG_ENABLE) begin
            enable_ff <= wdata_ff[`UEF_FLAG_W-1:0];
         end
         if (wr_sel == UEF_REG_CTRL) begin
            host_mode_ff <= wdata_ff[`UEF_CTRL_HOST];
         end
      end
   end

   always_comb begin
      clr_vec = '0;
      if (wr_commit && wstrb_ff[0] &&
          (wr_sel == UEF_REG_FLAGS || wr_sel == UEF_REG_CLEAR)) begin
         clr_vec = wdata_ff[`UEF_FLAG_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   assign nxt_rvalid = rvalid_ff ? !s_axi_rready : (s_axi_arvalid && arready_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b0;
         rdata_ff   <= `UEF_RDATA_RST;
         rresp_ff   <= `UEF_RESP_OKAY;
      end else begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= !nxt_rvalid;
         if (s_axi_arvalid && arready_ff) begin
            rdata_ff <= `UEF_RDATA_RST;
            rresp_ff <= `UEF_RESP_OKAY;
            case (uef_decode(s_axi_araddr))
               UEF_REG_FLAGS:  rdata_ff[`UEF_FLAG_W-1:0] <= flags;
               UEF_REG_CLEAR:  rdata_ff[`UEF_FLAG_W-1:0] <= '0;
               UEF_REG_ENABLE: rdata_ff[`UEF_FLAG_W-1:0] <= enable_ff;
               UEF_REG_CTRL:   rdata_ff[`UEF_CTRL_HOST]  <= host_mode_ff;
               default:        rresp_ff                  <= `UEF_RESP_SLVERR;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Error detection
   // ----------------------------------------------------------------
   uef_turnaround_timer u_turn (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .eop_seen   (eop_seen),
      .resp_start (resp_start),
      .bit_tick   (bit_tick),
      .timeout    (turn_timeout)
   );

   always_comb begin
      set_vec = '0;
      set_vec[`UEF_BIT_STUFF]   = rx_pkt_end && rx_stuff_err;
      set_vec[`UEF_BIT_BUSADDR] = bdt_addr_err || buf_addr_err;
      set_vec[`UEF_BIT_MEMXFER] = mem_grant_late || (rx_pkt_end && rx_truncated);
      set_vec[`UEF_BIT_TURN]    = turn_timeout;
      set_vec[`UEF_BIT_DFSIZE]  = rx_pkt_end && rx_data_pkt && (rx_partial_bits != 3'h0);
      set_vec[`UEF_BIT_CRC16]   = rx_pkt_end && rx_data_pkt && !rx_crc16_ok;
      set_vec[`UEF_BIT_SHARED]  = host_mode_ff ? (sof_count_zero && link_busy)
                                               : (token_end && !token_crc5_ok);
      set_vec[`UEF_BIT_PID]     = pid_check && !pid_ok;
   end

   uef_sticky_flags u_flags (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_vec (set_vec),
      .clr_vec (clr_vec),
      .flags   (flags)
   );

   assign bad_pkt = rx_stuff_err || (rx_data_pkt && !rx_crc16_ok);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accept_ff <= 1'b0;
         reject_ff <= 1'b0;
      end else begin
         accept_ff <= rx_pkt_end && !bad_pkt;
         reject_ff <= rx_pkt_end && bad_pkt;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(flags & enable_ff);
      end
   end

   assign s_axi_awready   = awready_ff;
   assign s_axi_wready    = wready_ff;
   assign s_axi_bvalid    = bvalid_ff;
   assign s_axi_bresp     = bresp_ff;
   assign s_axi_arready   = arready_ff;
   assign s_axi_rvalid    = rvalid_ff;
   assign s_axi_rdata     = rdata_ff;
   assign s_axi_rresp     = rresp_ff;
   assign usb_error_flags = flags;
   assign rx_pkt_accept   = accept_ff;
   assign rx_pkt_reject   = reject_ff;
   assign irq             = irq_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   stuff_reject_a: assert property (
      rx_pkt_end && rx_stuff_err |=> flags[`UEF_BIT_STUFF] && rx_pkt_reject && !rx_pkt_accept)
      else $error("bit stuff error not flagged and rejected");
   addr_flag_a: assert property (
      bdt_addr_err || buf_addr_err |=> flags[`UEF_BIT_BUSADDR])
      else $error("address error not flagged");
   grant_flag_a: assert property (
      mem_grant_late |=> flags[`UEF_BIT_MEMXFER])
      else $error("late grant not flagged");
   trunc_flag_a: assert property (
      rx_pkt_end && rx_truncated |=> flags[`UEF_BIT_MEMXFER])
      else $error("truncation not flagged");
   turn_flag_a: assert property (
      turn_timeout |=> flags[`UEF_BIT_TURN])
      else $error("turnaround timeout not flagged");
   field_size_a: assert property (
      !flags[`UEF_BIT_DFSIZE] && !(rx_pkt_end && rx_data_pkt && rx_partial_bits != 3'h0)
      |=> !flags[`UEF_BIT_DFSIZE])
      else $error("field size flag set without cause");
   field_set_a: assert property (
      rx_pkt_end && rx_data_pkt && rx_partial_bits != 3'h0 |=> flags[`UEF_BIT_DFSIZE])
      else $error("partial byte field not flagged");
   crc16_pair_a: assert property (
      rx_pkt_end && rx_data_pkt && !rx_stuff_err
      |=> rx_pkt_accept == $past(rx_crc16_ok) && rx_pkt_reject == !$past(rx_crc16_ok)
          && (rx_pkt_accept || flags[`UEF_BIT_CRC16]))
      else $error("data CRC outcome wrong");
   eof_host_a: assert property (
      host_mode_ff && sof_count_zero && link_busy |=> flags[`UEF_BIT_SHARED])
      else $error("end of frame error not flagged");
   crc5_dev_a: assert property (
      !host_mode_ff && token_end && !token_crc5_ok |=> flags[`UEF_BIT_SHARED])
      else $error("token CRC error not flagged");
   w1c_clear_a: assert property (
      |(clr_vec & ~set_vec) |=> (flags & $past(clr_vec & ~set_vec)) == '0)
      else $error("write one did not clear");
   zero_keep_a: assert property (
      wr_commit |=> ($past(flags & ~clr_vec) & ~flags) == '0)
      else $error("flag lost without a one written");
   reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> flags == `UEF_FLAGS_RST)
      else $error("flags not clear after reset");
   upper_zero_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[`UEF_DATA_W-1:`UEF_FLAG_W] == '0)
      else $error("upper read bits not zero");
   pid_flag_a: assert property (
      pid_check && !pid_ok |=> flags[`UEF_BIT_PID])
      else $error("identifier error not flagged");
   irq_follow_a: assert property (
      |(flags & enable_ff) |=> irq)
      else $error("interrupt not raised");

   reject_c: cover property (rx_pkt_end && rx_stuff_err ##1 rx_pkt_reject);
   irq_c: cover property ($rose(irq));
   clear_c: cover property (flags[`UEF_BIT_PID] ##[1:20] !flags[`UEF_BIT_PID]);
   eof_c: cover property (host_mode_ff && flags[`UEF_BIT_SHARED]);

endmodule // uef_top
`default_nettype wire

// >>> hw/uef_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the USB error flag block
// Assumes: Included by every design file that needs a constant
// Notes:   Definitions only
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define UEF_ADDR_W        8
`define UEF_DATA_W        32
`define UEF_FLAG_W        8

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define UEF_OFS_FLAGS     8'h00
`define UEF_OFS_CLEAR     8'h04
`define UEF_OFS_ENABLE    8'h08
`define UEF_OFS_CTRL      8'h0c

// ----------------------------------------------------------------
// Flag positions in usb_error_flags and the host mode bit of the control register
// ----------------------------------------------------------------
`define UEF_BIT_STUFF     7
`define UEF_BIT_BUSADDR   6
`define UEF_BIT_MEMXFER   5
`define UEF_BIT_TURN      4
`define UEF_BIT_DFSIZE    3
`define UEF_BIT_CRC16     2
`define UEF_BIT_SHARED    1
`define UEF_BIT_PID       0
`define UEF_CTRL_HOST     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UEF_FLAGS_RST     8'h00
`define UEF_ENABLE_RST    8'h00
`define UEF_RDATA_RST     32'h0000_0000

// ----------------------------------------------------------------
// Responses and counts
// ----------------------------------------------------------------
`define UEF_RESP_OKAY     2'h0
`define UEF_RESP_SLVERR   2'h2
`define UEF_TA_CNT_W      5
`define UEF_TA_LIMIT      5'h10

`endif

// >>> hw/uef_pkg.sv
// Purpose: Types shared by the USB error flag block
// Assumes: Constants live in uef_defs.svh
// Notes:   Types only
`default_nettype none
package uef_pkg;

   // ----------------------------------------------------------------
   // Register selection
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      UEF_REG_FLAGS  = 3'h0,
      UEF_REG_CLEAR  = 3'h1,
      UEF_REG_ENABLE = 3'h2,
      UEF_REG_CTRL   = 3'h3,
      UEF_REG_NONE   = 3'h4
   } uef_reg_type;

   // ----------------------------------------------------------------
   // Turnaround watch states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      UEF_TA_IDLE = 2'b01,
      UEF_TA_WAIT = 2'b10
   } uef_ta_state_type;

endpackage
`default_nettype wire

// >>> hw/uef_sticky_flags.sv
// Purpose: Eight hardware-set, software-cleared sticky flags
// Assumes: Set and clear are single-cycle vectors
// Notes:   A set in the same cycle as a clear keeps the flag
`timescale 1ns/1ns
`default_nettype none
`include "uef_defs.svh"

module uef_sticky_flags (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`UEF_FLAG_W-1:0] set_vec,
   input  wire logic [`UEF_FLAG_W-1:0] clr_vec,
   output logic      [`UEF_FLAG_W-1:0] flags
);
   import uef_pkg::*;

   logic [`UEF_FLAG_W-1:0] flags_ff;

   // ----------------------------------------------------------------
   // Flag cells
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `UEF_FLAG_W; i = i + 1) begin : g_flag
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               flags_ff[i] <= 1'b0;
            end else if (set_vec[i]) begin
               flags_ff[i] <= 1'b1;
            end else if (clr_vec[i]) begin
               flags_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flags_ff;

endmodule // uef_sticky_flags
`default_nettype wire

// >>> hw/uef_turnaround_timer.sv
// Purpose: Watches idle bit times after an end of packet
// Assumes: bit_tick pulses once per bit time
// Notes:   A response or a new end of packet stops or restarts the watch
`timescale 1ns/1ns
`default_nettype none
`include "uef_defs.svh"

module uef_turnaround_timer (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic eop_seen,
   input  wire logic resp_start,
   input  wire logic bit_tick,
   output logic      timeout
);
   import uef_pkg::*;

   uef_ta_state_type          state_ff;
   uef_ta_state_type          nxt_state;
   logic [`UEF_TA_CNT_W-1:0]  cnt_ff;
   logic [`UEF_TA_CNT_W-1:0]  nxt_cnt;
   logic                      timeout_ff;
   logic                      nxt_timeout;

   // ----------------------------------------------------------------
   // Watch sequence
   // ----------------------------------------------------------------
   // more than sixteen idle bits
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_timeout = 1'b0;
      case (state_ff)
         UEF_TA_IDLE: begin
            if (eop_seen) begin
               nxt_state = UEF_TA_WAIT;
               nxt_cnt   = '0;
            end
         end
         UEF_TA_WAIT: begin
            if (resp_start) begin
               nxt_state = UEF_TA_IDLE;
            end else if (eop_seen) begin
               nxt_cnt = '0;
            end else if (bit_tick) begin
               if (cnt_ff == `UEF_TA_LIMIT) begin
                  nxt_timeout = 1'b1;
                  nxt_state   = UEF_TA_IDLE;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
         end
         default: begin
            nxt_state = UEF_TA_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff   <= UEF_TA_IDLE;
         cnt_ff     <= '0;
         timeout_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         timeout_ff <= nxt_timeout;
      end
   end

   assign timeout = timeout_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   ta_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
      timeout_ff |-> $past(cnt_ff) == `UEF_TA_LIMIT && $past(bit_tick))
      else $error("turnaround timeout fired at the wrong count");

endmodule // uef_turnaround_timer
`default_nettype wire

// >>> dv/uef_link_partner.sv
// Purpose: Far-side USB controller driving link events into the flag block
// Assumes: Events are driven just after a rising edge
// Notes:   Bit order of link_o matches the concatenation in the bench
`timescale 1ns/1ns
`default_nettype none
module uef_link_partner (
   input  wire logic        aclk,
   output logic      [19:0] link_o
);
   logic [19:0] pat [0:11];
   initial begin
      link_o = 20'h0;
      pat = '{20'hf0000, 20'h00800, 20'h00400, 20'h00200, 20'hd1000, 20'hd6000,
              20'hc0000, 20'h00008, 20'h00002, 20'h00030, 20'h00100, 20'hd0000};
   end
   task automatic send(input int c);
      @(posedge aclk);
      link_o <= pat[c];
      @(posedge aclk);
      link_o <= 20'h0;
      if (c == 10) begin
         repeat (17) begin
            @(posedge aclk);
            link_o <= 20'h00040;
            @(posedge aclk);
            link_o <= 20'h0;
         end
      end
   endtask
endmodule // uef_link_partner
`default_nettype wire

// >>> dv/tb_uef_top.sv
// Purpose: Self-checking bench for the USB error flag block
// Assumes: A monitor scores each read against a queue of notes
// Notes:   Each fault is raised, kept across a zero write, then cleared
`timescale 1ns/1ns
`default_nettype none
`include "uef_defs.svh"
module tb_uef_top;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, rx_pkt_end, rx_data_pkt, rx_stuff_err, rx_crc16_ok, rx_truncated;
   logic bdt_addr_err, buf_addr_err, mem_grant_late, eop_seen, resp_start, bit_tick;
   logic sof_count_zero, link_busy, token_end, token_crc5_ok, pid_check, pid_ok;
   logic rx_pkt_accept, rx_pkt_reject, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, usb_error_flags;
   logic [31:0] s_axi_wdata, s_axi_rdata, en;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  rx_partial_bits;
   logic [19:0] link_o;
   logic [33:0] exp_q [$];
   logic [1:0]  b_q [$], v_q [$];
   logic [7:0]  flag_exp [0:11] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h08,
                                    8'h04, 8'h02, 8'h01, 8'h02, 8'h10, 8'h00};
   int bad_count = 0, checked = 0, seed = 79, i;
   assign {rx_pkt_end, rx_data_pkt, rx_stuff_err, rx_crc16_ok, rx_partial_bits, rx_truncated,
           bdt_addr_err, buf_addr_err, mem_grant_late, eop_seen, resp_start, bit_tick,
           sof_count_zero, link_busy, token_end, token_crc5_ok, pid_check, pid_ok} = link_o;
   uef_top u_uef_top (.*);
   uef_link_partner u_uef_link_partner (.aclk(aclk), .link_o(link_o));
   always #50 aclk = ~aclk;
   task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      bad_count += exp_q.size() + v_q.size() + b_q.size();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Register bus master
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      b_q.push_back((a inside {`UEF_OFS_FLAGS, `UEF_OFS_CLEAR, `UEF_OFS_ENABLE, `UEF_OFS_CTRL})
                    ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      exp_q.push_back({r, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   task automatic pkt(input int c);
      if (u_uef_link_partner.pat[c][19])
         v_q.push_back((flag_exp[c] & 8'h84) != 8'h0 ? 2'b01 : 2'b10);
      u_uef_link_partner.send(c);
   endtask
   task automatic chk_irq(input logic e);
      @(posedge aclk);
      cmp("irq", {33'h0, e}, {33'h0, irq});
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
         cmp("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         cmp("bresp", {32'h0, b_q.pop_front()}, {32'h0, s_axi_bresp});
      if (rx_pkt_accept || rx_pkt_reject)
         cmp("verdict", {32'h0, v_q.pop_front()}, {32'h0, rx_pkt_accept, rx_pkt_reject});
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`UEF_OFS_FLAGS, 32'h0, `UEF_RESP_OKAY);
      for (i = 0; i < 12; i++) begin
         wr(`UEF_OFS_CTRL, {31'h0, i == 9});
         pkt(i);
         repeat (2) @(posedge aclk);
         cmp("flags", {26'h0, flag_exp[i]}, {26'h0, usb_error_flags});
         rd(`UEF_OFS_FLAGS, {24'h0, flag_exp[i]}, `UEF_RESP_OKAY);
         wr(`UEF_OFS_FLAGS, $random(seed) & 32'hffff_ff00);
         rd(`UEF_OFS_FLAGS, {24'h0, flag_exp[i]}, `UEF_RESP_OKAY);
         wr(i[0] ? `UEF_OFS_CLEAR : `UEF_OFS_FLAGS, {24'h0, flag_exp[i]});
         rd(`UEF_OFS_FLAGS, 32'h0, `UEF_RESP_OKAY);
         $display("test event %0d done", i);
      end
      en = $random(seed);
      wr(`UEF_OFS_ENABLE, en);
      rd(`UEF_OFS_ENABLE, {24'h0, en[7:0]}, `UEF_RESP_OKAY);
      wr(`UEF_OFS_ENABLE, 32'h7f);
      pkt(0);
      chk_irq(1'b0);
      wr(`UEF_OFS_ENABLE, 32'h80);
      chk_irq(1'b1);
      s_axi_wstrb <= 4'he;
      wr(`UEF_OFS_FLAGS, 32'hff);
      s_axi_wstrb <= 4'hf;
      chk_irq(1'b1);
      wr(`UEF_OFS_FLAGS, 32'h80);
      chk_irq(1'b0);
      wr(8'h10, 32'hff);
      rd(8'h10, 32'h0, `UEF_RESP_SLVERR);
      pkt(0);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`UEF_OFS_FLAGS, 32'h0, `UEF_RESP_OKAY);
      repeat (2) @(posedge aclk);
      $display("test irq and map done");
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      complete_run;
   end
endmodule // tb_uef_top
`default_nettype wire
